// ---- common/pag_pkg.sv ----
// package: register map, field positions and reset values of the port a block
`default_nettype none
package pag_pkg;
	localparam int PA_W = 6;
	localparam logic [11:0] OFF_VALUE = 12'h000;
	localparam logic [11:0] OFF_LATCH = 12'h004;
	localparam logic [11:0] OFF_DIR = 12'h008;
	localparam logic [11:0] OFF_ANALOG = 12'h00c;
	localparam logic [11:0] OFF_PULLUP = 12'h010;
	localparam logic [11:0] OFF_THRESH = 12'h014;
	localparam logic [11:0] OFF_OPTION = 12'h018;
	localparam logic [11:0] OFF_ALTSEL = 12'h01c;
	localparam logic [11:0] OFF_PERIPH = 12'h020;
	// reset values and write masks
	localparam logic [5:0] DIR_RST = 6'h3f;
	localparam logic [5:0] ANALOG_RST = 6'h17;
	localparam logic [5:0] ANALOG_MASK = 6'h17;
	localparam logic [5:0] PULLUP_RST = 6'h3f;
	localparam logic [5:0] THRESH_RST = 6'h04;
	localparam logic [5:0] LATCH_MASK = 6'h37;
	localparam logic [3:0] ALTSEL_RST = 4'h0;
	// field positions
	localparam int PIN_IN_ONLY = 3;
	localparam int SEL_CAP2 = 0;
	localparam int SEL_PWM2B = 1;
	localparam int SEL_PWM1C = 2;
	localparam int SEL_PWM1D = 3;
	localparam int OPT_PU_DIS = 7;
	localparam int PIN4 = 4;
	localparam int PIN5 = 5;
	localparam int PC0 = 0;
	localparam int PC1 = 1;
	localparam int PC2 = 2;
	localparam int PC3 = 3;
endpackage : pag_pkg
`default_nettype wire

// ---- hdl/pag_port_a.sv ----
// port a general purpose i/o with pwm/capture pin steering and apb registers
// Function
// RULE1 - steering bit 3 puts pwm1 output d on port c pin 2 or pin 0
// RULE2 - steering bit 2 puts pwm1 output c on port c pin 3 or pin 1
// RULE3 - steering bit 1 puts pwm2 output b on port c pin 2 or port a pin 4
// RULE4 - steering bit 0 puts capture/compare 2 on port c pin 3 or port a pin 5
// RULE5 - six bidirectional pins with direction, latch, pull-up and threshold bits
// RULE6 - direction 1 makes input; direction 0 drives the latch bit out
// RULE7 - pin 3 is input only; its direction bit always reads 1
// RULE8 - value reads return pin levels; value writes go to the output latch
// RULE9 - port writes are read-modify-write of sampled pins into the latch; the code loads the written data straight into the latch
// RULE10 - direction still drives analog pins; analog pins read digital 0
// RULE11 - per-pin schmitt or ttl threshold governs reads and change detection
// RULE12 - software changes thresholds only with peripherals disabled
// RULE13 - per-pin pull-up enable, forced off whenever the pin is output
// RULE14 - global pull-up disable set at reset keeps all pull-ups off
// RULE15 - analog select forces digital reads to 0 and feeds analog functions
// RULE16 - analog select does not affect digital output driving
// RULE17 - among enabled sources on a pin, lowest priority number wins
// RULE18 - digital sources may drive pins in analog mode, same priority
// RULE19 - pin 3 has no output sources and no arbitration
// RULE20 - fixed priority lists for pins 0, 1, 2 and 4
// RULE21 - steering never alters direction; overrides follow the function's pin
`timescale 1ns/1ps
`default_nettype none
module pag_port_a #(
	parameter int WIDTH = pag_pkg::PA_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port a pins
	input wire logic [5:0] pa_in,
	output logic [5:0] pa_out,
	output logic [5:0] pa_oe,
	output logic [5:0] pa_pullup_on,
	output logic [5:0] pa_schmitt_sel,
	output logic [5:0] pa_analog_en,
	// port c pins driven by steered functions
	output logic [3:0] pc_out,
	output logic [3:0] pc_oe,
	// peripheral output sources: data and enable each
	input wire logic prog_data_o,
	input wire logic prog_data_en,
	input wire logic debug_data_o,
	input wire logic debug_data_en,
	input wire logic dac_o,
	input wire logic dac_en,
	input wire logic prog_clk_o,
	input wire logic prog_clk_en,
	input wire logic debug_clk_o,
	input wire logic debug_clk_en,
	input wire logic serial_rx_o,
	input wire logic serial_rx_en,
	input wire logic sr_latch_o,
	input wire logic sr_latch_en,
	input wire logic cmp1_o,
	input wire logic cmp1_en,
	input wire logic cap3_o,
	input wire logic cap3_en,
	input wire logic clk_out_o,
	input wire logic clk_out_en,
	input wire logic tmr_osc_o,
	input wire logic tmr_osc_en,
	input wire logic ref_clk_o,
	input wire logic ref_clk_en,
	input wire logic spi_out_o,
	input wire logic spi_out_en,
	input wire logic pwm2_output_b,
	input wire logic pwm2_b_en,
	input wire logic pwm1_output_c,
	input wire logic pwm1_c_en,
	input wire logic pwm1_output_d,
	input wire logic pwm1_d_en,
	input wire logic capture_compare_2,
	input wire logic capture_compare_2_en
);
	// synchronised, threshold-qualified pin levels
	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	logic [5:0] pin_read;
	// registers
	logic [5:0] port_a_output_latch_r;
	logic [5:0] port_a_direction_r;
	logic [5:0] port_a_analog_select_r;
	logic [5:0] port_a_pullup_enable_r;
	logic [5:0] port_a_input_threshold_r;
	logic global_pullup_disable_r;
	logic [3:0] alt_pin_select_1_r;
	// output path next values
	logic [5:0] pa_out_nxt;
	logic [5:0] pa_oe_nxt;
	logic [3:0] pc_out_nxt;
	logic [3:0] pc_oe_nxt;
	logic [31:0] rdata_nxt;
	logic wr_acc;
	logic rd_acc;
	logic map_hit;

	// pick the first enabled source of up to five, else the port latch
	function automatic logic [1:0] prio5(input logic [4:0] en, input logic [4:0] d,
		input logic lat, input logic dir_out);
		logic [1:0] r;
		r = {dir_out, lat};
		for (int i = 4; i >= 0; i--)
			if (en[i])
				r = {1'b1, d[i]};
		return r;
	endfunction : prio5

	// two-flop synchroniser on the pads; only the second stage is read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
		end
		else
		begin
			pin_s1_r <= pa_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	// analog pins read 0 digitally; threshold choice is applied in the pad [RULE10] [RULE15]
	assign pin_read = pin_s2_r & ~port_a_analog_select_r;

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~pwrite;

	// value and latch writes load pwdata into the latch, pin 3 bit masked off [RULE8] [RULE9]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_a_output_latch_r <= 6'h00;
		else if (wr_acc && (paddr == pag_pkg::OFF_VALUE || paddr == pag_pkg::OFF_LATCH))
			port_a_output_latch_r <= pwdata[5:0] & pag_pkg::LATCH_MASK; // [RULE9]
	end

	// direction register; pin 3 bit held at 1 [RULE6] [RULE7] [RULE5]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_a_direction_r <= pag_pkg::DIR_RST;
		else if (wr_acc && paddr == pag_pkg::OFF_DIR)
			port_a_direction_r <= pwdata[5:0] | (6'h01 << pag_pkg::PIN_IN_ONLY); // [RULE7]
	end

	// pin configuration registers [RULE5] [RULE11] [RULE14]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_a_analog_select_r <= pag_pkg::ANALOG_RST;
			port_a_pullup_enable_r <= pag_pkg::PULLUP_RST;
			port_a_input_threshold_r <= pag_pkg::THRESH_RST;
			global_pullup_disable_r <= 1'b1; // [RULE14]
			alt_pin_select_1_r <= pag_pkg::ALTSEL_RST;
		end
		else if (wr_acc)
		begin
			unique case (paddr)
				pag_pkg::OFF_ANALOG: port_a_analog_select_r <= pwdata[5:0] & pag_pkg::ANALOG_MASK;
				pag_pkg::OFF_PULLUP: port_a_pullup_enable_r <= pwdata[5:0];
				pag_pkg::OFF_THRESH: port_a_input_threshold_r <= pwdata[5:0]; // [RULE11]
				pag_pkg::OFF_OPTION: global_pullup_disable_r <= pwdata[pag_pkg::OPT_PU_DIS];
				pag_pkg::OFF_ALTSEL: alt_pin_select_1_r <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero and flag an error
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		map_hit = 1'b1;
		unique case (paddr)
			pag_pkg::OFF_VALUE: rdata_nxt[5:0] = pin_read; // [RULE8]
			pag_pkg::OFF_LATCH: rdata_nxt[5:0] = port_a_output_latch_r;
			pag_pkg::OFF_DIR: rdata_nxt[5:0] = port_a_direction_r;
			pag_pkg::OFF_ANALOG: rdata_nxt[5:0] = port_a_analog_select_r;
			pag_pkg::OFF_PULLUP: rdata_nxt[5:0] = port_a_pullup_enable_r;
			pag_pkg::OFF_THRESH: rdata_nxt[5:0] = port_a_input_threshold_r;
			pag_pkg::OFF_OPTION: rdata_nxt[pag_pkg::OPT_PU_DIS] = global_pullup_disable_r;
			pag_pkg::OFF_ALTSEL: rdata_nxt[3:0] = alt_pin_select_1_r;
			pag_pkg::OFF_PERIPH: rdata_nxt[5:0] = pa_oe & ~port_a_direction_r;
			default: map_hit = 1'b0;
		endcase
	end

	// apb answer: zero wait states, data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~map_hit;
			if (rd_acc && !penable)
			begin
				prdata <= rdata_nxt;
			end
		end
	end

	// output arbitration per pin; steering never touches direction bits [RULE17] [RULE18] [RULE21]
	always_comb
	begin
		logic [1:0] p;
		logic [5:0] drv;
		p = 2'b00;
		drv = ~port_a_direction_r; // [RULE6] [RULE16]
		pa_out_nxt = port_a_output_latch_r;
		pa_oe_nxt = drv;
		// pin 0: programming data, debug data, dac [RULE20]
		p = prio5({2'b00, dac_en, debug_data_en, prog_data_en},
			{2'b00, dac_o, debug_data_o, prog_data_o}, port_a_output_latch_r[0], drv[0]);
		{pa_oe_nxt[0], pa_out_nxt[0]} = p;
		// pin 1: programming clock, debug clock, serial data [RULE20]
		p = prio5({2'b00, serial_rx_en, debug_clk_en, prog_clk_en},
			{2'b00, serial_rx_o, debug_clk_o, prog_clk_o}, port_a_output_latch_r[1], drv[1]);
		{pa_oe_nxt[1], pa_out_nxt[1]} = p;
		// pin 2: sr latch, comparator 1, capture 3 [RULE20]
		p = prio5({2'b00, cap3_en, cmp1_en, sr_latch_en},
			{2'b00, cap3_o, cmp1_o, sr_latch_o}, port_a_output_latch_r[2], drv[2]);
		{pa_oe_nxt[2], pa_out_nxt[2]} = p;
		// pin 3 is input only: never driven [RULE19]
		pa_oe_nxt[pag_pkg::PIN_IN_ONLY] = 1'b0;
		pa_out_nxt[pag_pkg::PIN_IN_ONLY] = 1'b0;
		// pin 4: clock out, timer osc, ref clock, spi out, pwm2 b when steered [RULE20] [RULE3]
		p = prio5({pwm2_b_en & alt_pin_select_1_r[pag_pkg::SEL_PWM2B], spi_out_en,
			ref_clk_en, tmr_osc_en, clk_out_en},
			{pwm2_output_b, spi_out_o, ref_clk_o, tmr_osc_o, clk_out_o},
			port_a_output_latch_r[pag_pkg::PIN4], drv[pag_pkg::PIN4]);
		{pa_oe_nxt[pag_pkg::PIN4], pa_out_nxt[pag_pkg::PIN4]} = p;
		// pin 5: capture/compare 2 when steered here [RULE4]
		if (capture_compare_2_en && alt_pin_select_1_r[pag_pkg::SEL_CAP2])
		begin
			pa_oe_nxt[pag_pkg::PIN5] = 1'b1;
			pa_out_nxt[pag_pkg::PIN5] = capture_compare_2;
		end
	end

	// port c steering; the unselected pin is left alone [RULE1] [RULE2] [RULE3] [RULE4]
	always_comb
	begin
		pc_out_nxt = 4'h0;
		pc_oe_nxt = 4'h0;
		// pc0 / pc2 carry pwm1 d [RULE1]
		if (pwm1_d_en && alt_pin_select_1_r[pag_pkg::SEL_PWM1D])
		begin
			pc_oe_nxt[pag_pkg::PC0] = 1'b1;
			pc_out_nxt[pag_pkg::PC0] = pwm1_output_d;
		end
		// pc2 also hosts pwm2 b; pwm1 d given precedence on a clash [RULE3]
		if (pwm2_b_en && !alt_pin_select_1_r[pag_pkg::SEL_PWM2B])
		begin
			pc_oe_nxt[pag_pkg::PC2] = 1'b1;
			pc_out_nxt[pag_pkg::PC2] = pwm2_output_b;
		end
		if (pwm1_d_en && !alt_pin_select_1_r[pag_pkg::SEL_PWM1D])
		begin
			pc_oe_nxt[pag_pkg::PC2] = 1'b1;
			pc_out_nxt[pag_pkg::PC2] = pwm1_output_d; // [RULE1]
		end
		// pc1 / pc3 carry pwm1 c [RULE2]
		if (pwm1_c_en && alt_pin_select_1_r[pag_pkg::SEL_PWM1C])
		begin
			pc_oe_nxt[pag_pkg::PC1] = 1'b1;
			pc_out_nxt[pag_pkg::PC1] = pwm1_output_c;
		end
		if (capture_compare_2_en && !alt_pin_select_1_r[pag_pkg::SEL_CAP2])
		begin
			pc_oe_nxt[pag_pkg::PC3] = 1'b1;
			pc_out_nxt[pag_pkg::PC3] = capture_compare_2; // [RULE4]
		end
		if (pwm1_c_en && !alt_pin_select_1_r[pag_pkg::SEL_PWM1C])
		begin
			pc_oe_nxt[pag_pkg::PC3] = 1'b1;
			pc_out_nxt[pag_pkg::PC3] = pwm1_output_c; // [RULE2]
		end
	end

	// registered pad controls; pull-up dropped for outputs or global disable [RULE13] [RULE14]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pa_out <= 6'h00;
			pa_oe <= 6'h00;
			pc_out <= 4'h0;
			pc_oe <= 4'h0;
			pa_pullup_on <= 6'h00;
			pa_schmitt_sel <= pag_pkg::THRESH_RST;
			pa_analog_en <= pag_pkg::ANALOG_RST;
		end
		else
		begin
			pa_out <= pa_out_nxt;
			pa_oe <= pa_oe_nxt;
			pc_out <= pc_out_nxt;
			pc_oe <= pc_oe_nxt;
			pa_pullup_on <= port_a_pullup_enable_r & ~pa_oe_nxt
				& {6{~global_pullup_disable_r}}; // [RULE13]
			pa_schmitt_sel <= port_a_input_threshold_r; // [RULE11]
			pa_analog_en <= port_a_analog_select_r; // [RULE15]
		end
	end

	// assertions
	property p_dir3_high;
		@(posedge pclk) disable iff (!presetn)
		port_a_direction_r[pag_pkg::PIN_IN_ONLY] && !pa_oe[pag_pkg::PIN_IN_ONLY];
	endproperty
	a_dir3_high: assert property (p_dir3_high) else $error("pin 3 driven or dir cleared"); // [RULE7]

	property p_pullup_off_out;
		@(posedge pclk) disable iff (!presetn)
		(pa_oe & pa_pullup_on) == 6'h00;
	endproperty
	a_pullup_off_out: assert property (p_pullup_off_out) else $error("pullup on output pin"); // [RULE13]

	property p_global_pu;
		@(posedge pclk) disable iff (!presetn)
		$past(global_pullup_disable_r) |-> pa_pullup_on == 6'h00;
	endproperty
	a_global_pu: assert property (p_global_pu) else $error("pullup on while disabled"); // [RULE14]

	property p_analog_read0;
		@(posedge pclk) disable iff (!presetn)
		(rd_acc && !penable && paddr == pag_pkg::OFF_VALUE)
			|=> (prdata[5:0] & $past(port_a_analog_select_r)) == 6'h00;
	endproperty
	a_analog_read0: assert property (p_analog_read0) else $error("analog pin read 1"); // [RULE15]

	property p_latch_drive;
		@(posedge pclk) disable iff (!presetn)
		(!port_a_direction_r[pag_pkg::PIN5] && !capture_compare_2_en) |=> pa_oe[pag_pkg::PIN5]
			&& pa_out[pag_pkg::PIN5] == $past(port_a_output_latch_r[pag_pkg::PIN5]);
	endproperty
	a_latch_drive: assert property (p_latch_drive) else $error("pin5 not driven from latch"); // [RULE6]

	property p_prio0;
		@(posedge pclk) disable iff (!presetn)
		prog_data_en |=> pa_oe[0] && pa_out[0] == $past(prog_data_o);
	endproperty
	a_prio0: assert property (p_prio0) else $error("pin0 priority wrong"); // [RULE17]

	property p_pc0_steer;
		@(posedge pclk) disable iff (!presetn)
		(pwm1_d_en && alt_pin_select_1_r[pag_pkg::SEL_PWM1D])
			|=> pc_oe[pag_pkg::PC0] && pc_out[pag_pkg::PC0] == $past(pwm1_output_d);
	endproperty
	a_pc0_steer: assert property (p_pc0_steer) else $error("pwm1 d not on pc0"); // [RULE1]

	property p_pc1_steer;
		@(posedge pclk) disable iff (!presetn)
		(!pwm1_c_en || !alt_pin_select_1_r[pag_pkg::SEL_PWM1C]) |=> !pc_oe[pag_pkg::PC1];
	endproperty
	a_pc1_steer: assert property (p_pc1_steer) else $error("pc1 driven unselected"); // [RULE2]

	property p_pa4_pwm2b;
		@(posedge pclk) disable iff (!presetn)
		(pwm2_b_en && !alt_pin_select_1_r[pag_pkg::SEL_PWM2B] && port_a_direction_r[pag_pkg::PIN4]
			&& !(clk_out_en | tmr_osc_en | ref_clk_en | spi_out_en)) |=> !pa_oe[pag_pkg::PIN4];
	endproperty
	a_pa4_pwm2b: assert property (p_pa4_pwm2b) else $error("pwm2 b on pa4 unselected"); // [RULE3]

	property p_capture_compare_2_pa5;
		@(posedge pclk) disable iff (!presetn)
		(capture_compare_2_en && alt_pin_select_1_r[pag_pkg::SEL_CAP2]) |=> pa_oe[pag_pkg::PIN5]
			&& pa_out[pag_pkg::PIN5] == $past(capture_compare_2)
			&& (!pc_oe[pag_pkg::PC3]
			|| $past(pwm1_c_en && !alt_pin_select_1_r[pag_pkg::SEL_PWM1C]));
	endproperty
	a_capture_compare_2_pa5: assert property (p_capture_compare_2_pa5) else $error("capture_compare_2 steering wrong"); // [RULE4]
endmodule : pag_port_a
`default_nettype wire

// ---- testbench/pag_pad_model.sv ----
// board-side model of the six port a pads
`timescale 1ns/1ps
`default_nettype none
module pag_pad_model (
	// clock
	input wire logic pclk,
	// pad controls from the device
	input wire logic [5:0] pa_out,
	input wire logic [5:0] pa_oe,
	input wire logic [5:0] pa_pullup_on,
	// external drivers on the board
	input wire logic [5:0] ext_val,
	input wire logic [5:0] ext_en,
	// level seen by the device
	output logic [5:0] pa_in
);
	logic [5:0] last_r;
	// the device driver beats a weak board driver; a floating pin wanders, so it shows
	// the inverse of its last level instead of a value the simulator would pick
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			if (pa_oe[i])
				pa_in[i] = pa_out[i];
			else if (ext_en[i])
				pa_in[i] = ext_val[i];
			else if (pa_pullup_on[i])
				pa_in[i] = 1'b1;
			else
				pa_in[i] = ~last_r[i];
		end
	end
	// history of the pad level for the floating case
	initial last_r = 6'h00;
	always @(posedge pclk)
		last_r <= pa_in;
endmodule : pag_pad_model
`default_nettype wire

// ---- testbench/test_port_a_gpio_with_pin_steering.sv ----
// self-checking bench for the port a block with pin steering
`timescale 1ns/1ps
`default_nettype none
module test_port_a_gpio_with_pin_steering;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [5:0] pa_in, pa_out, pa_oe, pa_pullup_on, pa_schmitt_sel, pa_analog_en;
	logic [5:0] ext_val, ext_en, dir_v, lat_v, an_v, pu_v, th_v, v_v;
	logic [3:0] pc_out, pc_oe;
	logic [16:0] src_o, src_en, en_v, o_v;
	logic [19:0] x_v;
	int miscompares, n_tests, cycles;
	// pad of each source, 9 meaning none on port a
	localparam int PIN_OF [17] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 4, 4, 4, 4, 4, 9, 9, 5};
	localparam logic [11:0] RST_A [6] = '{12'h008, 12'h00c, 12'h010, 12'h014, 12'h01c, 12'h004};
	localparam logic [5:0] RST_V [6] = '{6'h3f, 6'h17, 6'h3f, 6'h04, 6'h00, 6'h00};

	pag_port_a pag_port_a_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
		.pa_pullup_on(pa_pullup_on), .pa_schmitt_sel(pa_schmitt_sel),
		.pa_analog_en(pa_analog_en), .pc_out(pc_out), .pc_oe(pc_oe),
		.prog_data_o(src_o[0]), .prog_data_en(src_en[0]), .debug_data_o(src_o[1]),
		.debug_data_en(src_en[1]), .dac_o(src_o[2]), .dac_en(src_en[2]),
		.prog_clk_o(src_o[3]), .prog_clk_en(src_en[3]), .debug_clk_o(src_o[4]),
		.debug_clk_en(src_en[4]), .serial_rx_o(src_o[5]), .serial_rx_en(src_en[5]),
		.sr_latch_o(src_o[6]), .sr_latch_en(src_en[6]), .cmp1_o(src_o[7]), .cmp1_en(src_en[7]),
		.cap3_o(src_o[8]), .cap3_en(src_en[8]), .clk_out_o(src_o[9]), .clk_out_en(src_en[9]),
		.tmr_osc_o(src_o[10]), .tmr_osc_en(src_en[10]), .ref_clk_o(src_o[11]),
		.ref_clk_en(src_en[11]), .spi_out_o(src_o[12]), .spi_out_en(src_en[12]),
		.pwm2_output_b(src_o[13]), .pwm2_b_en(src_en[13]), .pwm1_output_c(src_o[14]),
		.pwm1_c_en(src_en[14]), .pwm1_output_d(src_o[15]), .pwm1_d_en(src_en[15]),
		.capture_compare_2(src_o[16]), .capture_compare_2_en(src_en[16]));

	pag_pad_model pag_pad_model_i (.pclk(pclk), .pa_out(pa_out), .pa_oe(pa_oe),
		.pa_pullup_on(pa_pullup_on), .ext_val(ext_val), .ext_en(ext_en), .pa_in(pa_in));

	// 50 ns clock
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// cycle ceiling well above the roughly 1750 cycles the run needs
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim;
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one apb transfer; an idle edge first keeps psel from being assigned twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the cycle ceiling ends a hung wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask : rd

	// expected pad drive: latch where direction is output, peripherals on top by priority
	function automatic logic [19:0] exp_pins(input logic [3:0] sel, input logic [16:0] en, o,
		input logic [5:0] dir, lat);
		logic [5:0] oe, out;
		logic [3:0] coe, cout;
		int p;
		oe = ~dir & 6'h37;
		out = lat & oe;
		coe = 4'h0;
		cout = 4'h0;
		// lowest priority first so the winner is written last
		for (int i = 16; i >= 0; i--)
		begin
			p = PIN_OF[i];
			if ((i == 13 && !sel[1]) || (i == 16 && !sel[0]))
				p = 9;
			if (en[i] && p < 6)
			begin
				oe[p] = 1'b1;
				out[p] = o[i];
			end
		end
		if (en[16] && !sel[0])
		begin
			coe[3] = 1'b1;
			cout[3] = o[16];
		end
		if (en[13] && !sel[1])
		begin
			coe[2] = 1'b1;
			cout[2] = o[13];
		end
		p = sel[2] ? 1 : 3;
		coe[p] = coe[p] | en[14];
		cout[p] = en[14] ? o[14] : cout[p];
		p = sel[3] ? 0 : 2;
		coe[p] = coe[p] | en[15];
		cout[p] = en[15] ? o[15] : cout[p];
		return {coe, cout, oe, out};
	endfunction : exp_pins

	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{src_o, src_en, ext_val} = '0;
		ext_en = 6'h3f;
		miscompares = 0;
		n_tests = 0;
		cycles = 0;
		void'($urandom(32'h4d7bd1a4));
		repeat (4) @(posedge pclk);
		chk({pa_schmitt_sel, pa_analog_en, pa_pullup_on, pa_oe}, {6'h04, 6'h17, 12'h000});
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(RST_A[i], 32'(RST_V[i]));
		rd(pag_pkg::OFF_OPTION, 32'h80);
		apb(1'b0, 12'h040, 32'h0);
		chk(32'(err_v), 32'h1);
		chk(rd_v, 32'h0);
		// all pins are inputs with pull-ups enabled, yet the global disable keeps them off
		chk(32'(pa_pullup_on), 32'h0);
		apb(1'b1, pag_pkg::OFF_OPTION, 32'h0);
		repeat (2) @(posedge pclk);
		chk(32'(pa_pullup_on), 32'h3f);
		// random configuration, steering and peripheral traffic
		for (int i = 0; i < 40; i++)
		begin
			{dir_v, lat_v, an_v, pu_v} = 24'($urandom);
			en_v = 17'($urandom);
			o_v = 17'($urandom);
			// corner: pwm2 b kept off pin 4, which is an input with no other source
			if (i % 4 == 1)
			begin
				en_v[12:9] = 4'h0;
				en_v[13] = 1'b1;
				dir_v[4] = 1'b1;
			end
			apb(1'b1, pag_pkg::OFF_ALTSEL, 32'(i % 16));
			apb(1'b1, pag_pkg::OFF_DIR, 32'(dir_v));
			apb(1'b1, pag_pkg::OFF_LATCH, 32'(lat_v));
			apb(1'b1, pag_pkg::OFF_ANALOG, 32'(an_v));
			apb(1'b1, pag_pkg::OFF_PULLUP, 32'(pu_v));
			src_en <= en_v;
			src_o <= o_v;
			repeat (3) @(posedge pclk);
			#1;
			x_v = exp_pins(4'(i % 16), en_v, o_v, dir_v | 6'h08, lat_v);
			chk({pc_oe, pc_out & pc_oe, pa_oe, pa_out & pa_oe}, x_v);
			chk(32'(pa_pullup_on), 32'(pu_v & ~x_v[11:6]));
			rd(pag_pkg::OFF_PERIPH, 32'(x_v[11:6] & ~(dir_v | 6'h08)));
			chk(pa_analog_en, an_v & 6'h17);
			rd(pag_pkg::OFF_DIR, 32'(dir_v | 6'h08));
			rd(pag_pkg::OFF_ALTSEL, 32'(i % 16));
		end
		src_en <= '0;
		// pin reads, threshold select and value writes into the latch
		for (int i = 0; i < 20; i++)
		begin
			{an_v, ext_val, th_v, v_v} = 24'($urandom);
			apb(1'b1, pag_pkg::OFF_THRESH, 32'(th_v)); // peripherals are off here
			apb(1'b1, pag_pkg::OFF_ANALOG, 32'(an_v));
			apb(1'b1, pag_pkg::OFF_DIR, 32'h3f);
			repeat (4) @(posedge pclk);
			chk(pa_schmitt_sel, th_v);
			rd(pag_pkg::OFF_VALUE, 32'(ext_val & ~(an_v & 6'h17)));
			apb(1'b1, pag_pkg::OFF_DIR, 32'h0);
			apb(1'b1, pag_pkg::OFF_VALUE, 32'(v_v));
			repeat (4) @(posedge pclk);
			rd(pag_pkg::OFF_LATCH, 32'(v_v & 6'h37));
			rd(pag_pkg::OFF_VALUE, 32'(((v_v & 6'h37) | (ext_val & 6'h08)) & ~(an_v & 6'h17)));
		end
		end_sim();
	end
endmodule : test_port_a_gpio_with_pin_steering
`default_nettype wire
